/* hw/tpg_pkg.sv */
package tpg_pkg;

   // =========================================================
   // Register map (byte addresses)
   // =========================================================
   localparam logic [7:0] ADDR_CTRL        = 8'h00;
   localparam logic [7:0] ADDR_UNLOCK_PER  = 8'h04;
   localparam logic [7:0] ADDR_UNLOCK_WID  = 8'h08;
   localparam logic [7:0] ADDR_LOCK_PER    = 8'h0C;
   localparam logic [7:0] ADDR_LOCK_WID    = 8'h10;
   localparam logic [7:0] ADDR_CABLE_DLY   = 8'h14;
   localparam logic [7:0] ADDR_USER_DLY    = 8'h18;
   localparam logic [7:0] ADDR_STATUS      = 8'h1C;
   localparam logic [7:0] ADDR_REPORT_TIME = 8'h20;
   localparam logic [7:0] ADDR_REPORT_QERR = 8'h24;

   // =========================================================
   // Control field positions
   // =========================================================
   localparam int CTRL_ENA_BIT     = 0;
   localparam int CTRL_FREQ_BIT    = 1;
   localparam int CTRL_RATIO_BIT   = 2;
   localparam int CTRL_LOCKED_BIT  = 3;
   localparam int CTRL_FLOCK_BIT   = 4;
   localparam int CTRL_ALIGN_BIT   = 5;
   localparam int CTRL_POL_BIT     = 6;
   localparam int CTRL_GRID_LSB    = 8;
   localparam int CTRL_UTCSEL_LSB  = 12;

   // =========================================================
   // Reset values
   // =========================================================
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0041;
   localparam logic [31:0] PERIOD_RESET    = 32'h000F_4240;
   localparam logic [31:0] WIDTH_RESET     = 32'h0001_86A0;
   localparam logic [31:0] DELAY_RESET     = 32'h0000_0000;

   // =========================================================
   // Timing
   // =========================================================
   localparam int CLK_MHZ          = 250;
   localparam int CYC_PER_US       = CLK_MHZ;
   localparam int US_PER_SECOND    = 1000000;
   localparam int PCT_FULL         = 100;

   // =========================================================
   // Time grid and UTC variant codes
   // =========================================================
   typedef enum logic [2:0] {
      GRID_UTC     = 3'h0,
      GRID_GPS     = 3'h1,
      GRID_GLONASS = 3'h2,
      GRID_BEIDOU  = 3'h3,
      GRID_GALILEO = 3'h4
   } grid_e;

   typedef enum logic [2:0] {
      UTC_AUTO = 3'h0,
      UTC_USNO = 3'h1,
      UTC_SU   = 3'h2,
      UTC_NTSC = 3'h3,
      UTC_EU   = 3'h4
   } utc_variant_e;

   // Timing status from the navigation engine
   typedef struct packed {
      logic valid_time;
      logic utc_params_ok;
      logic grid_locked;
      logic gps_on;
      logic glo_on;
      logic bds_on;
      logic gal_on;
   } nav_status_s;

endpackage

/* hw/tpg_axil_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tpg_axil_regs
   import tpg_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // Register contents
   output logic [31:0]      o_ctrl,
   output logic [31:0]      o_unlock_per,
   output logic [31:0]      o_unlock_wid,
   output logic [31:0]      o_lock_per,
   output logic [31:0]      o_lock_wid,
   output logic [31:0]      o_cable_dly,
   output logic [31:0]      o_user_dly,
   // Read-only sources
   input  wire logic [31:0] i_status,
   input  wire logic [31:0] i_rep_time,
   input  wire logic [31:0] i_rep_qerr
);

   // =========================================================
   // Write channel
   // =========================================================
   logic [7:0] aw_addr;
   logic       aw_held;
   logic       w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire        aw_take   = i_awvalid & o_awready;
   wire        w_take    = i_wvalid & o_wready;
   wire        do_write  = aw_held & w_held & ~o_bvalid;
   wire        wr_mapped = (aw_addr <= ADDR_USER_DLY) && (aw_addr[1:0] == 2'b00);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr   <= 8'h00;
         w_data    <= 32'h0000_0000;
         w_strb    <= 4'h0;
         o_bvalid  <= 1'b0;
         o_bresp   <= 2'b00;
      end else begin
         if (aw_take) begin
            aw_held   <= 1'b1;
            aw_addr   <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (w_take) begin
            w_held   <= 1'b1;
            w_data   <= i_wdata;
            w_strb   <= i_wstrb;
            o_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp  <= wr_mapped ? 2'b00 : 2'b10;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_ctrl       <= CTRL_RESET;
         o_unlock_per <= PERIOD_RESET;
         o_unlock_wid <= WIDTH_RESET;
         o_lock_per   <= PERIOD_RESET;
         o_lock_wid   <= WIDTH_RESET;
         o_cable_dly  <= DELAY_RESET;
         o_user_dly   <= DELAY_RESET;
      end else if (do_write) begin
         unique case (aw_addr)
            ADDR_CTRL:       o_ctrl       <= merge(o_ctrl, w_data, w_strb);
            ADDR_UNLOCK_PER: o_unlock_per <= merge(o_unlock_per, w_data, w_strb);
            ADDR_UNLOCK_WID: o_unlock_wid <= merge(o_unlock_wid, w_data, w_strb);
            ADDR_LOCK_PER:   o_lock_per   <= merge(o_lock_per, w_data, w_strb);
            ADDR_LOCK_WID:   o_lock_wid   <= merge(o_lock_wid, w_data, w_strb);
            ADDR_CABLE_DLY:  o_cable_dly  <= merge(o_cable_dly, w_data, w_strb);
            ADDR_USER_DLY:   o_user_dly   <= merge(o_user_dly, w_data, w_strb);
            default: ;
         endcase
      end
   end

   // =========================================================
   // Read channel
   // =========================================================
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (i_araddr)
         ADDR_CTRL:        rd_mux = o_ctrl;
         ADDR_UNLOCK_PER:  rd_mux = o_unlock_per;
         ADDR_UNLOCK_WID:  rd_mux = o_unlock_wid;
         ADDR_LOCK_PER:    rd_mux = o_lock_per;
         ADDR_LOCK_WID:    rd_mux = o_lock_wid;
         ADDR_CABLE_DLY:   rd_mux = o_cable_dly;
         ADDR_USER_DLY:    rd_mux = o_user_dly;
         ADDR_STATUS:      rd_mux = i_status;
         ADDR_REPORT_TIME: rd_mux = i_rep_time;
         ADDR_REPORT_QERR: rd_mux = i_rep_qerr;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_ok  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= 2'b00;
      end else begin
         if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_mux;
            o_rresp   <= rd_ok ? 2'b00 : 2'b10;
         end
         if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

/* hw/tpg_cycle_calc.sv */
`timescale 1ns/1ps
`default_nettype none
module tpg_cycle_calc
   import tpg_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // Selected settings
   input  wire logic [31:0] i_period_val,
   input  wire logic [31:0] i_width_val,
   input  wire logic        i_is_freq,
   input  wire logic        i_is_ratio,
   input  wire logic [15:0] i_cyc_per_us,
   // Cycle counts, registered
   output logic [39:0]      o_period_cyc,
   output logic [39:0]      o_width_cyc
);

   // =========================================================
   // Period in cycles, then width from period or microseconds
   // =========================================================
   logic [47:0] per_us_cyc;
   logic [47:0] sec_cyc;
   logic [47:0] freq_cyc;
   logic [47:0] per_sel;
   logic [47:0] wid_us_cyc;
   logic [47:0] wid_pct_cyc;
   logic [31:0] freq_div;

   assign per_us_cyc  = 48'(i_period_val) * 48'(i_cyc_per_us);
   assign sec_cyc     = 48'(US_PER_SECOND) * 48'(i_cyc_per_us);
   assign freq_div    = (i_period_val == 32'h0000_0000) ? 32'h0000_0001 : i_period_val;
   assign freq_cyc    = sec_cyc / 48'(freq_div);
   assign per_sel     = i_is_freq ? freq_cyc : per_us_cyc;
   assign wid_us_cyc  = 48'(i_width_val) * 48'(i_cyc_per_us);
   assign wid_pct_cyc = (48'(o_period_cyc) * 48'(i_width_val)) / 48'(PCT_FULL);

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_period_cyc <= 40'h00_0000_0000;
         o_width_cyc  <= 40'h00_0000_0000;
      end else begin
         o_period_cyc <= per_sel[39:0];
         o_width_cyc  <= i_is_ratio ? wid_pct_cyc[39:0] : wid_us_cyc[39:0];
      end
   end

endmodule
`default_nettype wire

/* hw/gnss_time_pulse_generator.sv */
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Pulses only while the output enable bit is set.
// (R2) Type bit picks frequency or period for the timing value.
// (R3) Type bit picks width in microseconds or ratio in percent.
// (R4) Positive cable delay moves every pulse earlier; code applies it only while second alignment is in effect.
// (R5) Unlocked period rules unless locked setting enabled and in effect.
// (R6) Locked period and width used once valid time exists, if enabled.
// (R7) Width sets how long each pulse stays active.
// (R8) Positive user delay retards pulses, negative advances them; code applies it only while second alignment is in effect.
// (R9) Frequency lock uses the disciplined rate instead of local oscillator.
// (R10) Alignment option places edges on whole-second grid boundaries.
// (R11) Polarity set gives rising first edge, clear gives falling.
// (R12) Grid codes 0 UTC, 1 GPS, 2 GLONASS, 3 BeiDou, 4 Galileo.
// (R13) Host never programs width longer than period.
// (R14) Host keeps high and low phases at 50 ns or longer.
// (R15) Automatic UTC variant prefers USNO, SU, NTSC, then European.
// (R16) Pulse input shares output time base; UTC output implies GPS input.
// (R17) UTC grid withholds pulses until conversion data is received.
// (R18) Report at 1 Hz describes next pulse, last one most accurate.
// (R19) Host should set measurement rate and pulse frequency to 1 Hz.
// (R20) Same locked and unlocked period keeps rate; alignment needs grid lock.
// (R21) Host should pick a grid matching enabled satellite signals.
// (R22) Disabled or idle output rests at the polarity's inactive level.
module gnss_time_pulse_generator
   import tpg_pkg::*;
#(
   parameter int SECOND_CYC = CYC_PER_US * US_PER_SECOND
)
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // Navigation engine status and second marker
   input  wire nav_status_s i_nav,
   input  wire logic        i_grid_second,
   input  wire logic [15:0] i_disc_cyc_per_us,
   input  wire logic [31:0] i_grid_sec_count,
   // Pulse output, time base and report
   output logic             o_time_pulse,
   output logic [2:0]       o_input_time_base,
   output logic [2:0]       o_utc_variant,
   output logic             o_report_valid,
   output logic [31:0]      o_report_time
);

   // =========================================================
   // Registers
   // =========================================================
   logic [31:0] ctrl;
   logic [31:0] unlock_per;
   logic [31:0] unlock_wid;
   logic [31:0] lock_per;
   logic [31:0] lock_wid;
   logic [31:0] cable_dly;
   logic [31:0] user_dly;
   logic [31:0] rep_qerr;
   logic [31:0] status_word;

   tpg_axil_regs u_regs (
      .i_clk        (i_clk),
      .i_resetn     (i_resetn),
      .i_awaddr     (i_awaddr),
      .i_awvalid    (i_awvalid),
      .o_awready    (o_awready),
      .i_wdata      (i_wdata),
      .i_wstrb      (i_wstrb),
      .i_wvalid     (i_wvalid),
      .o_wready     (o_wready),
      .o_bresp      (o_bresp),
      .o_bvalid     (o_bvalid),
      .i_bready     (i_bready),
      .i_araddr     (i_araddr),
      .i_arvalid    (i_arvalid),
      .o_arready    (o_arready),
      .o_rdata      (o_rdata),
      .o_rresp      (o_rresp),
      .o_rvalid     (o_rvalid),
      .i_rready     (i_rready),
      .o_ctrl       (ctrl),
      .o_unlock_per (unlock_per),
      .o_unlock_wid (unlock_wid),
      .o_lock_per   (lock_per),
      .o_lock_wid   (lock_wid),
      .o_cable_dly  (cable_dly),
      .o_user_dly   (user_dly),
      .i_status     (status_word),
      .i_rep_time   (o_report_time),
      .i_rep_qerr   (rep_qerr)
   );

   // =========================================================
   // Control decode
   // =========================================================
   wire       pulse_output_enable     = ctrl[CTRL_ENA_BIT];
   wire       freq_type               = ctrl[CTRL_FREQ_BIT];
   wire       width_or_ratio_select   = ctrl[CTRL_RATIO_BIT];
   wire       use_locked_setting      = ctrl[CTRL_LOCKED_BIT];
   wire       freq_lock               = ctrl[CTRL_FLOCK_BIT];
   wire       second_alignment_enable = ctrl[CTRL_ALIGN_BIT];
   wire       first_edge_polarity     = ctrl[CTRL_POL_BIT];
   wire [2:0] pulse_time_grid         = ctrl[CTRL_GRID_LSB +: 3];
   wire [2:0] utc_variant_select      = ctrl[CTRL_UTCSEL_LSB +: 3];

   // =========================================================
   // Navigation status synchronisers
   // =========================================================
   logic [9:0] nav_meta;
   logic [9:0] nav_sync;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         nav_meta <= 10'h000;
         nav_sync <= 10'h000;
      end else begin
         nav_meta <= {i_grid_second, i_nav, 2'b00};
         nav_sync <= nav_meta;
      end
   end
   wire sec_lvl     = nav_sync[9];
   wire valid_time  = nav_sync[8];
   wire utc_ok      = nav_sync[7];
   wire grid_locked = nav_sync[6];
   wire gps_on      = nav_sync[5];
   wire glo_on      = nav_sync[4];
   wire bds_on      = nav_sync[3];
   wire gal_on      = nav_sync[2];
   logic sec_lvl_d;
   wire  sec_edge = sec_lvl & ~sec_lvl_d;

   // =========================================================
   // Setting selection
   // =========================================================
   // (R6) locked values once time valid
   wire        use_lock   = use_locked_setting & valid_time;
   // (R5) unlocked period otherwise
   wire [31:0] period_val = use_lock ? lock_per : unlock_per;
   wire [31:0] width_val  = use_lock ? lock_wid : unlock_wid;
   // (R9) disciplined cycles per microsecond
   wire [15:0] cyc_per_us = (freq_lock && valid_time) ? i_disc_cyc_per_us : 16'(CYC_PER_US);

   logic [39:0] period_cyc;
   logic [39:0] width_cyc;
   // (R2) (R3) type settings steer conversion
   tpg_cycle_calc u_calc (
      .i_clk        (i_clk),
      .i_resetn     (i_resetn),
      .i_period_val (period_val),
      .i_width_val  (width_val),
      .i_is_freq    (freq_type),
      .i_is_ratio   (width_or_ratio_select),
      .i_cyc_per_us (cyc_per_us),
      .o_period_cyc (period_cyc),
      .o_width_cyc  (width_cyc)
   );

   // =========================================================
   // UTC variant and time base
   // =========================================================
   logic [2:0] auto_variant;
   // (R15) automatic preference order
   assign auto_variant = gps_on ? UTC_USNO : glo_on ? UTC_SU : bds_on ? UTC_NTSC : gal_on ? UTC_EU : UTC_USNO;
   wire [2:0] variant = (utc_variant_select == UTC_AUTO) ? auto_variant : utc_variant_select;
   // (R12) UTC grid code
   wire       grid_is_utc = (pulse_time_grid == GRID_UTC);
   // (R17) withhold until conversion data
   wire       utc_block = grid_is_utc & ~utc_ok;
   // (R20) alignment only while grid locked
   wire       align_now = second_alignment_enable & grid_locked;

   // =========================================================
   // Pulse timing
   // =========================================================
   // (R4) (R8) net offset: user delay minus cable delay, in cycles
   wire signed [47:0] offset_us = 48'(signed'(user_dly)) - 48'(signed'(cable_dly));
   wire signed [63:0] offset_cyc = 64'(offset_us) * 64'(signed'({1'b0, cyc_per_us}));
   wire signed [63:0] sec_len   = 64'(SECOND_CYC);
   wire signed [63:0] off_wrap  = (offset_cyc < 0) ? offset_cyc + sec_len : offset_cyc;
   wire        [39:0] align_tgt = off_wrap[39:0];

   logic [39:0] phase;
   logic [39:0] sec_phase;
   logic        armed;
   wire         run_ok   = pulse_output_enable & ~utc_block & (period_cyc != 40'h00_0000_0000);
   wire         wrap     = (phase + 40'h00_0000_0001 >= period_cyc);
   wire         align_hit = align_now & ((sec_edge ? 40'h0 : sec_phase) == align_tgt);
   // (R7) active while phase below width
   wire         active   = armed & (phase < width_cyc);

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sec_lvl_d <= 1'b0;
         sec_phase <= 40'h00_0000_0000;
         phase     <= 40'h00_0000_0000;
         armed     <= 1'b0;
      end else begin
         sec_lvl_d <= sec_lvl;
         sec_phase <= sec_edge ? 40'h00_0000_0001 : sec_phase + 40'h00_0000_0001;
         // (R1) stop when disabled
         if (!run_ok) begin
            armed <= 1'b0;
            phase <= 40'h00_0000_0000;
         // (R10) restart on shifted second boundary
         end else if (align_hit) begin
            armed <= 1'b1;
            phase <= 40'h00_0000_0000;
         end else if (!align_now || armed) begin
            armed <= 1'b1;
            phase <= wrap ? 40'h00_0000_0000 : phase + 40'h00_0000_0001;
         end
      end
   end

   // =========================================================
   // Outputs and report
   // =========================================================
   logic        active_d;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_time_pulse      <= 1'b0;
         o_input_time_base <= GRID_GPS;
         o_utc_variant     <= UTC_USNO;
         o_report_valid    <= 1'b0;
         o_report_time     <= 32'h0000_0000;
         rep_qerr          <= 32'h0000_0000;
         active_d          <= 1'b0;
      end else begin
         active_d <= active;
         // (R11) (R22) polarity sets active and idle level
         o_time_pulse <= first_edge_polarity ? active : ~active;
         // (R16) UTC output implies GPS input
         o_input_time_base <= grid_is_utc ? GRID_GPS : pulse_time_grid;
         o_utc_variant     <= variant;
         // (R18) one report per second for next pulse
         o_report_valid <= sec_edge & run_ok;
         if (sec_edge && run_ok) begin
            o_report_time <= i_grid_sec_count + 32'h0000_0001;
            rep_qerr      <= {8'h00, period_cyc[23:0] - phase[23:0]};
         end
      end
   end

   assign status_word = {22'h00_0000, o_utc_variant, active_d, armed, align_now,
                         utc_block, use_lock, valid_time, o_time_pulse};

endmodule
`default_nettype wire

/* test/tpg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tpg_monitor (
   input wire logic        i_clk, i_resetn, i_awvalid, o_awready, i_wvalid, o_wready,
   input wire logic        o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready,
   input wire logic        o_report_valid, o_time_pulse,
   input wire logic [1:0]  o_rresp,
   input wire logic [31:0] o_rdata, i_grid_sec_count, o_report_time,
   input wire logic [2:0]  o_input_time_base, o_utc_variant
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // ========
   // Time base and report
   a_base_legal: assert property (o_input_time_base inside {[3'h1:3'h4]})
      else $error("input time base out of range");
   a_variant_legal: assert property (o_utc_variant inside {[3'h1:3'h4]})
      else $error("utc variant out of range");
   a_report_single: assert property (o_report_valid |=> !o_report_valid)
      else $error("report longer than one cycle");
   a_report_time: assert property (o_report_valid && $stable(i_grid_sec_count) |->
      o_report_time == i_grid_sec_count + 32'h1) else $error("report time wrong");
   // ========
   // Register bus
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data not held");
   a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
      else $error("write answer late");
   a_write_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped");
   a_ready_block: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("ready during response");
   c_report: cover property (o_report_valid);
   c_refused: cover property (o_rvalid && o_rresp == 2'h2);
   c_pulse: cover property ($rose(o_time_pulse));
endmodule
`default_nettype wire

/* test/pulse_meter.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_meter (
   // Clock and observed pulse
   input  wire logic   i_clk,
   input  wire logic   i_pulse,
   // Last lengths in cycles
   output logic [31:0] o_high,
   output logic [31:0] o_per
);
   logic        last = 1'b0;
   logic [31:0] hcnt = 32'h0;
   logic [31:0] pcnt = 32'h0;
   // ========
   // Rise to rise and rise to fall
   always_ff @(posedge i_clk) begin
      last <= i_pulse;
      pcnt <= (i_pulse && !last) ? 32'h1 : pcnt + 32'h1;
      hcnt <= (i_pulse && !last) ? 32'h1 : hcnt + {31'h0, i_pulse};
      if (i_pulse && !last) o_per <= pcnt;
      if (!i_pulse && last) o_high <= hcnt;
   end
endmodule
`default_nettype wire

/* test/tb_gnss_time_pulse_generator.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_gnss_time_pulse_generator;
   import tpg_pkg::*;
   logic        i_clk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_grid_second;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_time_pulse, o_report_valid;
   logic [7:0]  i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata, i_grid_sec_count, o_report_time, high_len, per_len, rd_val;
   logic [1:0]  o_bresp, o_rresp, resp;
   logic [2:0]  o_input_time_base, o_utc_variant;
   logic [3:0]  i_wstrb;
   logic [15:0] i_disc_cyc_per_us;
   nav_status_s i_nav;
   int          err_count = 0;
   int          checks_done = 0;

   gnss_time_pulse_generator #(.SECOND_CYC(2000)) dut (.*);
   pulse_meter pm (.i_clk(i_clk), .i_pulse(o_time_pulse), .o_high(high_len), .o_per(per_len));

   // ========
   // Clock, grid seconds, watchdog
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      i_grid_second <= 1'b0;
      i_grid_sec_count <= 32'h0;
      forever begin
         repeat (1000) @(posedge i_clk);
         i_grid_second <= ~i_grid_second;
         if (!i_grid_second) i_grid_sec_count <= i_grid_sec_count + 32'h1;
      end
   end
   initial begin
      #400000;
      err_count++;
      test_done();
   end

   // ========
   // Bus and check tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (!o_bvalid);
      resp = o_bresp;
      i_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_arready) i_arvalid <= 1'b0;
      end while (!o_rvalid);
      rd_val = o_rdata;
      resp = o_rresp;
      i_rready <= 1'b0;
   endtask
   task automatic cfg(input logic [31:0] c, input logic [31:0] p, input logic [31:0] w);
      wr(ADDR_CTRL, 32'h40);
      wr(ADDR_UNLOCK_PER, p);
      wr(ADDR_UNLOCK_WID, w);
      wr(ADDR_CTRL, c);
   endtask
   task automatic pulse_chk(input logic [31:0] p, input logic [31:0] h);
      repeat (5000) @(posedge i_clk);
      chk(per_len, p);
      chk(high_len, h);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ========
   // Main sequence
   initial begin
      {i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= 6'h0;
      {i_awaddr, i_araddr, i_wdata} <= 48'h0;
      i_wstrb <= 4'hF;
      i_disc_cyc_per_us <= 16'hFA;
      i_nav <= '0;
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(ADDR_CTRL);
      chk(rd_val, CTRL_RESET);
      chk({31'h0, o_time_pulse}, 32'h0);
      i_nav <= 7'h38;
      rd(8'h30);
      chk({30'h0, resp}, 32'h2);
      wr(8'h30, 32'h1);
      chk({30'h0, resp}, 32'h2);
      wr(ADDR_LOCK_PER, 32'h2);
      wr(ADDR_LOCK_WID, 32'h1);
      cfg(32'h49, 32'h4, 32'h1);
      pulse_chk(32'h3E8, 32'hFA);
      cfg(32'h4D, 32'h4, 32'h19);
      pulse_chk(32'h3E8, 32'hFA);
      cfg(32'h47, 32'h000F_4240, 32'h32);
      pulse_chk(32'hFA, 32'h7D);
      i_nav.valid_time <= 1'b1;
      i_disc_cyc_per_us <= 16'h1F4;
      cfg(32'h49, 32'h4, 32'h1);
      pulse_chk(32'h1F4, 32'hFA);
      cfg(32'h51, 32'h4, 32'h1);
      pulse_chk(32'h7D0, 32'h1F4);
      cfg(32'h61, 32'h4, 32'h1);
      pulse_chk(32'h3E8, 32'hFA);
      @(posedge i_grid_second);
      rd_val = 32'($time);
      @(posedge o_time_pulse);
      chk(32'($time) - rd_val, 32'h10);
      wr(ADDR_CTRL, 32'h40);
      repeat (3000) @(posedge i_clk);
      chk({31'h0, o_time_pulse}, 32'h0);
      wr(ADDR_CTRL, 32'h0);
      repeat (20) @(posedge i_clk);
      chk({31'h0, o_time_pulse}, 32'h1);
      for (int g = 0; g < 5; g++) begin
         wr(ADDR_CTRL, {21'h0, 3'(g), 8'h0});
         repeat (8) @(posedge i_clk);
         chk({29'h0, o_input_time_base}, (g == 0) ? 32'h1 : 32'(g));
      end
      for (int v = 0; v < 4; v++) begin
         i_nav <= {3'b100, 4'hF >> v};
         repeat (8) @(posedge i_clk);
         chk({29'h0, o_utc_variant}, 32'(v + 1));
      end
      test_done();
   end
endmodule
bind gnss_time_pulse_generator tpg_monitor mon (.*);
`default_nettype wire
